// >>> logic/csra_host.sv
// Implementation choice: the APB slave port.
module csra_host (
  // Clock and reset.
  input  logic        pclk,
  input  logic        presetn,
  // APB slave.
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [7:0]  paddr,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  // Serial link.
  csra_link_if.host   link
);
  import csra_pkg::*;

  logic               sdo_s1;
  logic               sdo_s2;
  logic               cfg_read;
  logic               cfg_short;
  logic               cfg_single;
  logic               cfg_ascend;
  logic               cfg_chk;
  logic [1:0]         cfg_count;
  logic [ADDR_W-1:0]  addr_r;
  logic [31:0]        wdata_r;
  logic [31:0]        rdata_r;
  logic               busy;
  logic               start_req;
  logic               next_cfg_read;
  logic               next_cfg_short;
  logic               next_cfg_single;
  logic               next_cfg_ascend;
  logic               next_cfg_chk;
  logic [1:0]         next_cfg_count;
  logic [ADDR_W-1:0]  next_addr_r;
  logic [31:0]        next_wdata_r;
  logic [31:0]        next_prdata;
  logic               next_pready;
  logic               next_pslverr;
  logic [7:0]         div;
  logic [7:0]         next_div;
  logic               sclk;
  logic               next_sclk;
  logic               cs_n;
  logic               next_cs_n;
  logic               sdi;
  logic               next_sdi;
  logic [15:0]        tx;
  logic [15:0]        next_tx;
  logic [4:0]         bits;
  logic [4:0]         next_bits;
  csra_unit_t         unit;
  csra_unit_t         next_unit;
  logic [1:0]         bytei;
  logic [1:0]         next_bytei;
  logic [ADDR_W-1:0]  cur_addr;
  logic [ADDR_W-1:0]  next_cur_addr;
  logic [31:0]        rx;
  logic [31:0]        next_rx;
  logic [31:0]        next_rdata_r;
  logic               next_busy;

  // Returning data is a pin, so it passes two flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sdo_s1 <= 1'b0;
      sdo_s2 <= 1'b0;
    end else begin
      sdo_s1 <= link.sdo;
      sdo_s2 <= sdo_s1;
    end
  end

  function automatic logic [15:0] instr_word(input logic rd, input logic sh,
                                             input logic [ADDR_W-1:0] a);
    instr_word = sh ? {rd, a[6:0], 8'h00} : {rd, a};
  endfunction

  function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] i);
    byte_of = w[{2'b11 - i, 3'b000} +: 8];
  endfunction

  // Register slave; answers in the first access cycle, no wait states.
  always_comb begin
    logic acc;
    acc             = psel & penable & pready & pwrite;
    next_pready     = psel & ~penable;
    next_pslverr    = 1'b0;
    next_prdata     = 32'h0000_0000;
    next_cfg_read   = cfg_read;
    next_cfg_short  = cfg_short;
    next_cfg_single = cfg_single;
    next_cfg_ascend = cfg_ascend;
    next_cfg_chk    = cfg_chk;
    next_cfg_count  = cfg_count;
    next_addr_r     = addr_r;
    next_wdata_r    = wdata_r;
    start_req       = 1'b0;
    if (psel & ~penable) begin
      unique case (paddr)
        HOST_CTRL:   next_prdata = {22'h00_0000, cfg_count, 2'b00, cfg_chk, cfg_ascend,
                                    cfg_single, cfg_short, cfg_read, 1'b0};
        HOST_ADDR:   next_prdata = {17'h0_0000, addr_r};
        HOST_WDATA:  next_prdata = wdata_r;
        HOST_RDATA:  next_prdata = rdata_r;
        HOST_STATUS: next_prdata = {31'h0000_0000, busy};
        default:     next_pslverr = 1'b1;
      endcase
    end
    // Settings are frozen while a frame runs.
    if (acc && !busy) begin
      unique case (paddr)
        HOST_CTRL: begin
          next_cfg_read   = pwdata[CTRL_READ];
          next_cfg_short  = pwdata[CTRL_SHORT];
          next_cfg_single = pwdata[CTRL_SINGLE];
          next_cfg_ascend = pwdata[CTRL_ASCEND];
          next_cfg_chk    = pwdata[CTRL_CHK];
          next_cfg_count  = pwdata[CTRL_COUNT +: 2];
          start_req       = pwdata[CTRL_START];
        end
        HOST_ADDR:  next_addr_r  = pwdata[ADDR_W-1:0];
        HOST_WDATA: next_wdata_r = pwdata;
        default:    next_wdata_r = wdata_r;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata     <= 32'h0000_0000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      cfg_read   <= 1'b0;
      cfg_short  <= 1'b0;
      cfg_single <= 1'b0;
      cfg_ascend <= 1'b0;
      cfg_chk    <= 1'b0;
      cfg_count  <= 2'b00;
      addr_r     <= 15'h0000;
      wdata_r    <= 32'h0000_0000;
    end else begin
      prdata     <= next_prdata;
      pready     <= next_pready;
      pslverr    <= next_pslverr;
      cfg_read   <= next_cfg_read;
      cfg_short  <= next_cfg_short;
      cfg_single <= next_cfg_single;
      cfg_ascend <= next_cfg_ascend;
      cfg_chk    <= next_cfg_chk;
      cfg_count  <= next_cfg_count;
      addr_r     <= next_addr_r;
      wdata_r    <= next_wdata_r;
    end
  end

  // Frame engine: bits go out on the falling edge, data is read just before it.
  always_comb begin
    logic        tick;
    logic        send;
    logic        byte_done;
    logic [15:0] tx_l;
    logic [4:0]  bits_l;
    tick          = busy && (div == 8'(SCLK_HALF_CYC - 1));
    send          = 1'b0;
    byte_done     = 1'b0;
    tx_l          = tx;
    bits_l        = bits;
    next_div      = busy ? (tick ? 8'h00 : div + 8'h01) : 8'h00;
    next_sclk     = sclk;
    next_cs_n     = cs_n;
    next_sdi      = sdi;
    next_tx       = tx;
    next_bits     = bits;
    next_unit     = unit;
    next_bytei    = bytei;
    next_cur_addr = cur_addr;
    next_rx       = rx;
    next_rdata_r  = rdata_r;
    next_busy     = busy;
    if (start_req) begin
      tx_l          = instr_word(pwdata[CTRL_READ], pwdata[CTRL_SHORT], addr_r);
      bits_l        = pwdata[CTRL_SHORT] ? 5'h08 : 5'h10;
      send          = 1'b1;
      next_cs_n     = 1'b0;
      next_unit     = unit_instr;
      next_bytei    = 2'b00;
      next_cur_addr = addr_r;
      next_rx       = 32'h0000_0000;
      next_busy     = 1'b1;
    end else if (tick && !sclk) begin
      next_sclk = 1'b1;
    end else if (tick) begin
      next_sclk = 1'b0;
      if (unit == unit_data && cfg_read) begin
        next_rx = {rx[30:0], sdo_s2};
      end
      send = 1'b1;
      if (bits == 5'h00) begin
        bits_l = 5'h08;
        unique case (unit)
          unit_instr: begin
            next_unit = unit_data;
            tx_l      = cfg_read ? 16'hFFFF : {byte_of(wdata_r, bytei), 8'h00};
          end
          unit_data: begin
            if (!cfg_read && cfg_chk) begin
              next_unit = unit_chk;
              tx_l      = {byte_of(wdata_r, bytei) ^ CHK_SEED, 8'h00};
            end else begin
              byte_done = 1'b1;
            end
          end
          unit_chk: byte_done = 1'b1;
        endcase
        if (byte_done) begin
          if (bytei == cfg_count) begin
            send         = 1'b0;
            next_cs_n    = 1'b1;
            next_busy    = 1'b0;
            next_rdata_r = next_rx;
          end else if (cfg_single) begin
            // Each access carries its own instruction.
            next_bytei    = bytei + 2'b01;
            next_cur_addr = cfg_ascend ? cur_addr + 15'h0001 : cur_addr - 15'h0001;
            next_unit     = unit_instr;
            tx_l          = instr_word(cfg_read, cfg_short, next_cur_addr);
            bits_l        = cfg_short ? 5'h08 : 5'h10;
          end else begin
            // Streaming: the device steps its own pointer.
            next_bytei = bytei + 2'b01;
            next_unit  = unit_data;
            tx_l       = cfg_read ? 16'hFFFF : {byte_of(wdata_r, next_bytei), 8'h00};
          end
        end
      end
    end
    if (send) begin
      next_sdi  = tx_l[15];
      next_tx   = {tx_l[14:0], 1'b0};
      next_bits = bits_l - 5'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div      <= 8'h00;
      sclk     <= 1'b0;
      cs_n     <= 1'b1;
      sdi      <= 1'b1;
      tx       <= 16'h0000;
      bits     <= 5'h00;
      unit     <= unit_instr;
      bytei    <= 2'b00;
      cur_addr <= 15'h0000;
      rx       <= 32'h0000_0000;
      rdata_r  <= 32'h0000_0000;
      busy     <= 1'b0;
    end else begin
      div      <= next_div;
      sclk     <= next_sclk;
      cs_n     <= next_cs_n;
      sdi      <= next_sdi;
      tx       <= next_tx;
      bits     <= next_bits;
      unit     <= next_unit;
      bytei    <= next_bytei;
      cur_addr <= next_cur_addr;
      rx       <= next_rx;
      rdata_r  <= next_rdata_r;
      busy     <= next_busy;
    end
  end

  assign link.cs_n = cs_n;
  assign link.sclk = sclk;
  assign link.sdi  = sdi;
endmodule // csra_host

// >>> logic/csra_pkg.sv
package csra_pkg;
  // Address field widths of the instruction word, and the data byte width.
  localparam int ADDR_W       = 15;
  localparam int SHORT_ADDR_W = 7;
  localparam int BYTE_W       = 8;

  // Interface configuration registers and their fields.
  localparam logic [14:0] REG_CFG_FIRST  = 15'h0000;
  localparam logic [14:0] REG_CFG_SECOND = 15'h0001;
  localparam int          ASCEND_BIT     = 5;
  localparam int          SINGLE_BIT     = 7;
  localparam logic [7:0]  CFG_FIRST_RST  = 8'h00;
  localparam logic [7:0]  CFG_SECOND_RST = 8'h00;

  // Check byte is data xor this seed; the value is arbitrary.
  localparam logic [7:0] CHK_SEED = 8'h5A;

  // Host register map on APB.
  localparam logic [7:0] HOST_CTRL   = 8'h00;
  localparam logic [7:0] HOST_ADDR   = 8'h04;
  localparam logic [7:0] HOST_WDATA  = 8'h08;
  localparam logic [7:0] HOST_RDATA  = 8'h0C;
  localparam logic [7:0] HOST_STATUS = 8'h10;
  localparam int CTRL_START  = 0;
  localparam int CTRL_READ   = 1;
  localparam int CTRL_SHORT  = 2;
  localparam int CTRL_SINGLE = 3;
  localparam int CTRL_ASCEND = 4;
  localparam int CTRL_CHK    = 5;
  localparam int CTRL_COUNT  = 8;

  // Link timing.
  localparam int PCLK_PERIOD_NS = 40;
  localparam int SCLK_PERIOD_NS = 320;
  localparam int SCLK_HALF_CYC  = SCLK_PERIOD_NS / (2 * PCLK_PERIOD_NS);

  typedef enum logic [1:0] {dev_idle, dev_instr, dev_data} csra_dev_state_t;
  typedef enum logic [1:0] {unit_instr, unit_data, unit_chk} csra_unit_t;
endpackage

// >>> logic/csra_link_if.sv
interface csra_link_if;
  logic cs_n;
  logic sclk;
  logic sdi;
  logic sdo;

  // Host drives select, clock and data in; the device drives data out.
  modport host (output cs_n, output sclk, output sdi, input sdo);
  modport dev (input cs_n, input sclk, input sdi, output sdo);
endinterface

// >>> logic/csra_dev.sv
// How it works
// - Command bit 0 after select falls: write.
// - Command bit 1: read from given address.
// - Address 15 bits, 7 in compact mode.
// - No checksum: commit each whole byte.
// - Checksum on: commit only on match.
// - Mismatch: drop all later bytes in frame.
// - SDO held low during write data phase.
// - Read data MSB first, changed on falling edge.
// - Reset leaves streaming mode selected.
// - Streaming: one instruction per frame.
// - Single mode: instruction per access, pointer fixed.
// - Pointer steps per byte by direction bit.
// - Direction bit sets only whether the pointer steps up or down.
// - Decrement below zero wraps to 0x7FFF.
// - Increment past maximum wraps to zero.
// - Host keeps SDI high during reads.
// - Single-mode bit is bit 7 at 0x01.
// - Direction bit lives at 0x00.
// - Write data sampled on SCLK rising edge.
// - Instruction ends on full packet or release.
module csra_dev #(
  parameter int NREG = 16
) (
  // Clock and reset.
  input  logic                         pclk,
  input  logic                         presetn,
  // Serial link.
  csra_link_if.dev                     link,
  // Configuration bits held elsewhere.
  input  logic                         short_instruction,
  input  logic                         checksum_enable,
  // Mode and status.
  output logic                         addr_ascend,
  output logic                         one_instruction_per_register,
  output logic                         frame_fault,
  // Register write report.
  output logic                         wr_strobe,
  output logic [csra_pkg::ADDR_W-1:0]  wr_addr,
  output logic [csra_pkg::BYTE_W-1:0]  wr_data
);
  import csra_pkg::*;

  localparam int IW = $clog2(NREG);

  logic                  cs_s1;
  logic                  cs_s2;
  logic                  sck_s1;
  logic                  sck_s2;
  logic                  sck_d;
  logic                  sdi_s1;
  logic                  sdi_s2;
  logic                  sck_rise;
  logic                  sck_fall;
  csra_dev_state_t       st;
  csra_dev_state_t       next_st;
  logic [3:0]            bitcnt;
  logic [3:0]            next_bitcnt;
  logic [15:0]           sh;
  logic [15:0]           next_sh;
  logic                  is_read;
  logic                  next_is_read;
  logic [ADDR_W-1:0]     ptr;
  logic [ADDR_W-1:0]     next_ptr;
  logic                  chk_phase;
  logic                  next_chk_phase;
  logic [7:0]            held;
  logic [7:0]            next_held;
  logic                  bad;
  logic                  next_bad;
  logic [7:0]            rd_sh;
  logic [7:0]            next_rd_sh;
  logic                  sdo;
  logic                  next_sdo;
  logic [7:0]            mem [NREG];
  logic [7:0]            next_mem [NREG];
  logic                  next_wr_strobe;
  logic [ADDR_W-1:0]     next_wr_addr;
  logic [7:0]            next_wr_data;

  // Pins pass two flops; the third sclk flop only serves edge finding.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_s1  <= 1'b1;
      cs_s2  <= 1'b1;
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_d  <= 1'b0;
      sdi_s1 <= 1'b1;
      sdi_s2 <= 1'b1;
    end else begin
      cs_s1  <= link.cs_n;
      cs_s2  <= cs_s1;
      sck_s1 <= link.sclk;
      sck_s2 <= sck_s1;
      sck_d  <= sck_s2;
      sdi_s1 <= link.sdi;
      sdi_s2 <= sdi_s1;
    end
  end

  assign sck_rise = sck_s2 & ~sck_d;
  assign sck_fall = ~sck_s2 & sck_d;

  // Unimplemented addresses read as zero.
  function automatic logic [7:0] rd_byte(input logic [ADDR_W-1:0] a);
    rd_byte = (a < ADDR_W'(NREG)) ? mem[a[IW-1:0]] : 8'h00;
  endfunction

  // Plain 15-bit arithmetic gives the fixed rollover at both ends.
  function automatic logic [ADDR_W-1:0] step(input logic [ADDR_W-1:0] a);
    step = addr_ascend ? a + 15'h0001 : a - 15'h0001;
  endfunction

  // Frame engine and configuration memory.
  always_comb begin
    logic [15:0]       sh_in;
    logic [3:0]        alen;
    logic [ADDR_W-1:0] a_new;
    logic              commit;
    logic [7:0]        commit_data;
    logic              entity_done;
    sh_in          = {sh[14:0], sdi_s2};
    alen           = short_instruction ? 4'h7 : 4'hF;
    a_new          = short_instruction ? {8'h00, sh_in[6:0]} : sh_in[14:0];
    commit         = 1'b0;
    commit_data    = sh_in[7:0];
    entity_done    = 1'b0;
    next_st        = st;
    next_bitcnt    = bitcnt;
    next_sh        = sh;
    next_is_read   = is_read;
    next_ptr       = ptr;
    next_chk_phase = chk_phase;
    next_held      = held;
    next_bad       = bad;
    next_rd_sh     = rd_sh;
    next_sdo       = sdo;
    next_mem       = mem;
    next_wr_strobe = 1'b0;
    next_wr_addr   = wr_addr;
    next_wr_data   = wr_data;
    if (cs_s2) begin
      // Release drops the frame and any half byte.
      next_st     = dev_idle;
      next_bitcnt = 4'h0;
      next_sdo    = 1'b0;
    end else begin
      unique case (st)
        dev_idle: begin
          next_st        = dev_instr;
          next_bitcnt    = 4'h0;
          next_bad       = 1'b0;
          next_chk_phase = 1'b0;
        end
        dev_instr: begin
          if (sck_rise) begin
            next_sh     = sh_in;
            next_bitcnt = bitcnt + 4'h1;
            if (bitcnt == alen) begin
              next_is_read = sh_in[alen];
              next_ptr     = a_new;
              next_rd_sh   = rd_byte(a_new);
              next_bitcnt  = 4'h0;
              next_st      = dev_data;
            end
          end
          if (sck_fall) begin
            next_sdo = 1'b0;
          end
        end
        dev_data: begin
          if (sck_rise) begin
            next_sh     = sh_in;
            next_bitcnt = bitcnt + 4'h1;
            if (bitcnt == 4'h7) begin
              next_bitcnt = 4'h0;
              if (is_read) begin
                entity_done = 1'b1;
              end else if (!checksum_enable) begin
                commit      = 1'b1;
                entity_done = 1'b1;
              end else if (!chk_phase) begin
                next_held      = sh_in[7:0];
                next_chk_phase = 1'b1;
              end else begin
                next_chk_phase = 1'b0;
                entity_done    = 1'b1;
                commit_data    = held;
                if (sh_in[7:0] == (held ^ CHK_SEED)) begin
                  commit = !bad;
                end else begin
                  next_bad = 1'b1;
                end
              end
              if (entity_done) begin
                if (one_instruction_per_register) begin
                  next_st = dev_instr;
                end else begin
                  next_ptr   = step(ptr);
                  next_rd_sh = rd_byte(step(ptr));
                end
              end
            end
          end
          if (sck_fall) begin
            next_sdo = is_read & rd_sh[7];
            if (is_read) begin
              next_rd_sh = {rd_sh[6:0], 1'b0};
            end
          end
        end
      endcase
    end
    if (commit) begin
      if (ptr < ADDR_W'(NREG)) begin
        next_mem[ptr[IW-1:0]] = commit_data;
      end
      next_wr_strobe = 1'b1;
      next_wr_addr   = ptr;
      next_wr_data   = commit_data;
    end
  end

  // Registers of the engine; config bytes reset to streaming, descending.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st        <= dev_idle;
      bitcnt    <= 4'h0;
      sh        <= 16'h0000;
      is_read   <= 1'b0;
      ptr       <= 15'h0000;
      chk_phase <= 1'b0;
      held      <= 8'h00;
      bad       <= 1'b0;
      rd_sh     <= 8'h00;
      sdo       <= 1'b0;
      wr_strobe <= 1'b0;
      wr_addr   <= 15'h0000;
      wr_data   <= 8'h00;
      for (int i = 0; i < NREG; i++) begin
        mem[i] <= (i == 0) ? CFG_FIRST_RST : (i == 1) ? CFG_SECOND_RST : 8'h00;
      end
    end else begin
      st        <= next_st;
      bitcnt    <= next_bitcnt;
      sh        <= next_sh;
      is_read   <= next_is_read;
      ptr       <= next_ptr;
      chk_phase <= next_chk_phase;
      held      <= next_held;
      bad       <= next_bad;
      rd_sh     <= next_rd_sh;
      sdo       <= next_sdo;
      wr_strobe <= next_wr_strobe;
      wr_addr   <= next_wr_addr;
      wr_data   <= next_wr_data;
      mem       <= next_mem;
    end
  end

  // Mode bits come straight from the configuration flops.
  assign addr_ascend                  = mem[REG_CFG_FIRST[IW-1:0]][ASCEND_BIT];
  assign one_instruction_per_register = mem[REG_CFG_SECOND[IW-1:0]][SINGLE_BIT];
  assign frame_fault                  = bad;
  assign link.sdo                     = sdo;
endmodule // csra_dev

// >>> verif/csra_properties.sv
module csra_properties (
  // Clock and reset.
  input logic pclk,
  input logic presetn,
  // Link wires.
  input logic cs_n,
  input logic sclk,
  input logic sdi,
  input logic sdo
);
  logic [8:0] rises;
  logic [8:0] next_rises;
  logic       wr_frame;
  logic       next_wr_frame;
  logic       sclk_q;
  logic       cs_q;
  logic [10:0] frame_len;
  logic [10:0] next_frame_len;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Count link clock rises per frame and keep the command bit, since sdo duty hangs on both.
  always_comb begin
    next_rises    = cs_n ? 9'h000 : rises + 9'(sclk & ~sclk_q);
    next_wr_frame = cs_n ? 1'h0 : (cs_q ? ~sdi : wr_frame);
    // The longest legal frame runs past a delay range, so its length is counted.
    next_frame_len = cs_n ? 11'h000 : frame_len + 11'h001;
  end

  // Registers only; reset matches an idle link.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rises    <= 9'h000;
      wr_frame <= 1'h0;
      sclk_q   <= 1'h0;
      cs_q     <= 1'h1;
      frame_len <= 11'h000;
    end else begin
      rises    <= next_rises;
      wr_frame <= next_wr_frame;
      sclk_q   <= sclk;
      cs_q     <= cs_n;
      frame_len <= next_frame_len;
    end
  end

  chk_reset_idle: assert property ($rose(presetn) |-> cs_n && !sclk && !sdo)
    else $error("link not idle after reset");
  chk_sclk_idle: assert property (cs_n |-> !sclk)
    else $error("link clock moves outside a frame");
  chk_sclk_high: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
    else $error("link clock high time wrong");
  chk_sclk_low: assert property ($fell(sclk) && !cs_n |-> !sclk[*4] ##1 sclk)
    else $error("link clock low time wrong");
  chk_sdi_hold: assert property ($changed(sdi) |-> $fell(sclk) || $changed(cs_n))
    else $error("sdi changed away from a falling edge");
  chk_sdo_on_fall: assert property ($changed(sdo) && !cs_n |-> !sclk)
    else $error("sdo changed while link clock high");
  chk_write_quiet: assert property (wr_frame && rises > 9'h010 |-> !sdo)
    else $error("sdo not low in write data phase");
  chk_whole_bytes: assert property ($rose(cs_n) |-> rises[2:0] == 3'h0 && rises >= 9'h008)
    else $error("frame ended on a partial byte");
  chk_frame_end: assert property (!cs_n |-> frame_len < 11'h410)
    else $error("frame never released");
endmodule // csra_properties

// >>> verif/config_spi_register_access_tb.sv
module config_spi_register_access_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import csra_pkg::*;

  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic        short_instruction = 1'h0, checksum_enable = 1'h0, pready, pslverr, pe;
  logic        addr_ascend, one_instruction_per_register, frame_fault, wr_strobe;
  logic [7:0]  paddr = 8'h00, wr_data, mem [16] = '{default: 8'h00};
  logic [14:0] wr_addr;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, r;
  logic [22:0] expq [$];
  int          failures = 0, tests_run = 0;

  // Clock at 25 MHz.
  always #20 pclk = ~pclk;

  csra_link_if csra_link_if_i ();
  csra_host csra_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(csra_link_if_i.host));
  csra_dev csra_dev_i (.pclk(pclk), .presetn(presetn), .link(csra_link_if_i.dev),
    .short_instruction(short_instruction), .checksum_enable(checksum_enable),
    .addr_ascend(addr_ascend), .one_instruction_per_register(one_instruction_per_register),
    .frame_fault(frame_fault), .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data));
  csra_properties csra_properties_i (.pclk(pclk), .presetn(presetn),
    .cs_n(csra_link_if_i.cs_n), .sclk(csra_link_if_i.sclk),
    .sdi(csra_link_if_i.sdi), .sdo(csra_link_if_i.sdo));

  // Automatic, since the commit watcher and the main sequence may both call it.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task test_done;
    if (failures == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task hang;
    failures++;
    test_done();
  endtask

  // One APB transfer; a spare edge first, so psel is never driven twice in one step.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (pready !== 1'h1) hang();
    rd = prdata;
    pe = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  // Runs one frame; expected commits and read data come from a byte model of the memory.
  // A set c[7] marks a frame whose writes must all be dropped; the host ignores that bit.
  task run(input logic [9:0] c, input logic [14:0] a, input logic [31:0] d);
    logic [14:0] p;
    logic [31:0] ex;
    int n;
    ex = 32'h0000_0000;
    for (int k = 0; k <= int'(c[9:8]); k++) begin
      p = a + (c[4] ? 15'(k) : -15'(k));
      ex = {ex[23:0], p < 15'h0010 ? mem[p[3:0]] : 8'h00};
      if (!c[1] && !c[7]) begin
        expq.push_back({p, d[31-8*k -: 8]});
        if (p < 15'h0010) mem[p[3:0]] = d[31-8*k -: 8];
      end
    end
    apb(1'h1, HOST_ADDR, {17'h0_0000, a});
    apb(1'h1, HOST_WDATA, d);
    apb(1'h1, HOST_CTRL, {22'h00_0000, c[9:1], 1'h1});
    n = 0;
    do begin
      apb(1'h0, HOST_STATUS, 32'h0000_0000);
      n++;
    end while (rd[0] !== 1'h0 && n < 400);
    if (rd[0] !== 1'h0) hang();
    if (c[1]) begin
      apb(1'h0, HOST_RDATA, 32'h0000_0000);
      check(rd, ex);
    end
  endtask

  // Each commit on the device side is matched against the oldest noted one.
  always @(posedge pclk) begin
    if (wr_strobe === 1'h1) begin
      check({9'h000, wr_addr, wr_data}, expq.size() ? {9'h000, expq.pop_front()} : 32'hdead_beef);
    end
  end

  initial begin
    void'($urandom(56));
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    check({29'h0, addr_ascend, one_instruction_per_register, frame_fault}, 32'h0);
    r = $urandom();
    run(10'h300, 15'h0009, r);
    run(10'h302, 15'h0009, 32'h0000_0000);
    run(10'h100, 15'h0000, {8'h00, r[23:0]});
    short_instruction <= 1'h1;
    run(10'h004, 15'h0005, r);
    run(10'h306, 15'h0008, 32'h0000_0000);
    short_instruction <= 1'h0;
    checksum_enable <= 1'h1;
    run(10'h120, 15'h000C, r);
    check({31'h0, frame_fault}, 32'h0);
    // Host sends no check bytes, so the device pairs them up: first pair fails, second matches.
    run(10'h380, 15'h000C, 32'h1122_3369);
    check({31'h0, frame_fault}, 32'h1);
    checksum_enable <= 1'h0;
    run(10'h000, 15'h0000, 32'h2000_0000);
    check({31'h0, addr_ascend}, 32'h1);
    run(10'h110, 15'h7FFF, {r[31:24], 8'h20, 16'h0000});
    run(10'h312, 15'h000C, 32'h0000_0000);
    run(10'h010, 15'h0001, 32'h8000_0000);
    check({31'h0, one_instruction_per_register}, 32'h1);
    run(10'h318, 15'h000A, $urandom());
    run(10'h31A, 15'h000A, 32'h0000_0000);
    apb(1'h0, 8'h14, 32'h0000_0000);
    check({rd[31:1], pe}, 32'h1);
    check(32'(expq.size()), 32'h0);
    test_done();
  end
endmodule // config_spi_register_access_tb
